//--- design/sbc_ctrl.sv
// Operation
// - Command flag clears on start, release, disable, reset
// - Manual ack: trigger drives at next falling
// - Auto ack set early: ack at ninth falling
// - Auto ack set late: ack next falling
// - Ack flag clears at first falling after new start, disable
// - Ack flag sets on sampled ack after transfer
// - Busy disable stops busy at next falling
// - Busy enabled: busy after acknowledge bit
// - New transfer ends busy; enable kept
// - Trigger bits 0, 1, 4 read zero
// - Status bits 2, 3, 6 are read-only
// - Free-bus trigger sets output latch, self-clears
// - Mode bit 7 zero stops channel, clears flags
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module sbc_ctrl #(
  parameter int unsigned FRAME_BITS = sbc_pkg::SBC_FRAME_BITS
) (
  input  wire logic                         clk_sys,    // System clock, 100 MHz
  input  wire logic                         rst,        // Async reset, active high
  input  wire logic [sbc_pkg::SBC_AW-1:0]   reg_addr,   // Register address
  input  wire logic [sbc_pkg::SBC_DW-1:0]   reg_wdata,  // Register write data
  input  wire logic                         reg_wr,     // Write strobe
  input  wire logic                         reg_rd,     // Read strobe
  output logic      [sbc_pkg::SBC_DW-1:0]   reg_rdata,  // Read data, cycle after strobe
  input  wire logic                         xfer_start, // Transfer start pulse
  input  wire logic                         sck_in,     // Serial clock pin level
  input  wire logic                         sda_in,     // Serial data line level
  output logic                              sda_out,    // Data line drive value
  output logic                              sda_oe,     // Data line drive enable
  output logic                              xfer_done,  // Frame data bits complete
  output logic                              irq         // Level interrupt
);
  import sbc_pkg::*;

  localparam int unsigned CW = 4;
  localparam logic [CW-1:0] FRAME_CNT = CW'(FRAME_BITS);
  localparam logic [CW-1:0] ACK_CNT   = CW'(FRAME_BITS + 1);

  initial begin
    if (FRAME_BITS < 1 || FRAME_BITS > 13) begin
      $error("FRAME_BITS out of range");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s1_ff, sck_s2_ff, sck_s3_ff;
  logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
  logic nxt_sck_s1, nxt_sck_s2, nxt_sck_s3;
  logic nxt_sda_s1, nxt_sda_s2, nxt_sda_s3;

  always_comb begin
    nxt_sck_s1 = sck_in;
    nxt_sck_s2 = sck_s1_ff;
    nxt_sck_s3 = sck_s2_ff;
    nxt_sda_s1 = sda_in;
    nxt_sda_s2 = sda_s1_ff;
    nxt_sda_s3 = sda_s2_ff;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_s1_ff <= 1'b1;
      sck_s2_ff <= 1'b1;
      sck_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      sck_s1_ff <= nxt_sck_s1;
      sck_s2_ff <= nxt_sck_s2;
      sck_s3_ff <= nxt_sck_s3;
      sda_s1_ff <= nxt_sda_s1;
      sda_s2_ff <= nxt_sda_s2;
      sda_s3_ff <= nxt_sda_s3;
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic bus_cmd;
  logic bus_free;

  assign sck_rise = sck_s2_ff & ~sck_s3_ff;
  assign sck_fall = ~sck_s2_ff & sck_s3_ff;
  // Data edges while the clock stays high mark bus conditions
  assign bus_cmd  = sck_s2_ff & sck_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign bus_free = sck_s2_ff & sck_s3_ff & ~sda_s3_ff & sda_s2_ff;

  // ----------------------------------------------------------------
  // Control and handshake state
  // ----------------------------------------------------------------
  logic [SBC_DW-1:0]    mode_ff, nxt_mode;
  logic                 ack_auto_ff, nxt_ack_auto;
  logic                 busy_en_ff, nxt_busy_en;
  logic                 cmd_det_ff, nxt_cmd_det;
  logic                 free_det_ff, nxt_free_det;
  logic                 ack_det_ff, nxt_ack_det;
  logic                 ack_pend_ff, nxt_ack_pend;
  logic                 ack_drv_ff, nxt_ack_drv;
  logic                 busy_drv_ff, nxt_busy_drv;
  logic                 busy_off_ff, nxt_busy_off;
  logic                 acknowledge_detected_clr_ff, nxt_acknowledge_detected_clr;
  logic                 so_latch_ff, nxt_so_latch;
  logic                 in_xfer_ff, nxt_in_xfer;
  logic [CW-1:0]        rise_cnt_ff, nxt_rise_cnt;
  logic [CW-1:0]        fall_cnt_ff, nxt_fall_cnt;
  logic                 done_ff, nxt_done;
  logic [SBC_IRQ_N-1:0] irq_st_ff, nxt_irq_st;
  logic [SBC_IRQ_N-1:0] irq_msk_ff, nxt_irq_msk;
  logic [SBC_DW-1:0]    rdata_ff, nxt_rdata;

  logic                 chan_en;
  logic                 wr_ctrl;
  logic [SBC_IRQ_N-1:0] ev;

  assign chan_en = mode_ff[SBC_B_CHAN_EN];
  assign wr_ctrl = reg_wr && (reg_addr == SBC_OFS_CTRL);

  always_comb begin
    nxt_mode     = mode_ff;
    nxt_ack_auto = ack_auto_ff;
    nxt_busy_en  = busy_en_ff;
    nxt_cmd_det  = cmd_det_ff;
    nxt_free_det = free_det_ff;
    nxt_ack_det  = ack_det_ff;
    nxt_ack_pend = ack_pend_ff;
    nxt_ack_drv  = ack_drv_ff;
    nxt_busy_drv = busy_drv_ff;
    nxt_busy_off = busy_off_ff;
    nxt_acknowledge_detected_clr = acknowledge_detected_clr_ff;
    nxt_so_latch = so_latch_ff;
    nxt_in_xfer  = in_xfer_ff;
    nxt_rise_cnt = rise_cnt_ff;
    nxt_fall_cnt = fall_cnt_ff;
    nxt_done     = 1'b0;
    nxt_irq_msk  = irq_msk_ff;
    ev           = '0;

    // Register writes; status bits 2, 3 and 6 are never taken
    if (reg_wr && reg_addr == SBC_OFS_MODE) begin
      nxt_mode = reg_wdata;
    end else if (wr_ctrl) begin
      nxt_busy_en  = reg_wdata[SBC_B_BUSY_EN];
      nxt_ack_auto = reg_wdata[SBC_B_ACK_AUTO];
      if (reg_wdata[SBC_B_ACK_TRIG]) begin
        nxt_ack_pend = 1'b1;
      end
      // Auto ack enabled after the data bits: answer on next falling
      if (reg_wdata[SBC_B_ACK_AUTO] && !ack_auto_ff
          && rise_cnt_ff >= FRAME_CNT) begin
        nxt_ack_pend = 1'b1;
      end
      if (!reg_wdata[SBC_B_BUSY_EN] && busy_en_ff) begin
        nxt_busy_off = 1'b1;
      end
      if (reg_wdata[SBC_B_FREE_TRIG]) begin
        nxt_so_latch = 1'b1;
      end else if (reg_wdata[SBC_B_CMD_TRIG]) begin
        nxt_so_latch = 1'b0;
      end
    end else if (reg_wr && reg_addr == SBC_OFS_IRQ_MSK) begin
      nxt_irq_msk = reg_wdata[SBC_IRQ_N-1:0];
    end

    // Bus conditions
    if (bus_cmd) begin
      nxt_cmd_det = 1'b1;
      ev[SBC_E_CMD] = 1'b1;
    end
    if (bus_free) begin
      nxt_free_det = 1'b1;
      nxt_cmd_det  = 1'b0;
      ev[SBC_E_FREE] = 1'b1;
    end

    // Serial clock rising: count bits, sample remote acknowledge
    if (sck_rise && in_xfer_ff) begin
      if (rise_cnt_ff < ACK_CNT) begin
        nxt_rise_cnt = rise_cnt_ff + 1'b1;
      end
      if (rise_cnt_ff == FRAME_CNT - 1'b1) begin
        nxt_done = 1'b1;
        ev[SBC_E_DONE] = 1'b1;
      end
      if (rise_cnt_ff == FRAME_CNT && !sda_s2_ff && !ack_drv_ff) begin
        nxt_ack_det = 1'b1;
        ev[SBC_E_ACK] = 1'b1;
      end
    end

    // Serial clock falling: ack and busy drive change here, apart from start and channel-off clears
    if (sck_fall) begin
      if (in_xfer_ff && fall_cnt_ff < ACK_CNT) begin
        nxt_fall_cnt = fall_cnt_ff + 1'b1;
      end
      if (acknowledge_detected_clr_ff) begin
        nxt_ack_det  = 1'b0;
        nxt_acknowledge_detected_clr = 1'b0;
      end
      if (busy_off_ff) begin
        nxt_busy_drv = 1'b0;
        nxt_busy_off = 1'b0;
      end
      if (ack_drv_ff) begin
        // One clock of acknowledge, then busy if enabled
        nxt_ack_drv  = 1'b0;
        nxt_busy_drv = busy_en_ff && !busy_off_ff;
      end else if (ack_pend_ff) begin
        nxt_ack_drv  = 1'b1;
        nxt_ack_pend = 1'b0;
      end else if (ack_auto_ff && in_xfer_ff
                   && fall_cnt_ff == FRAME_CNT) begin
        nxt_ack_drv = 1'b1;
      end
    end

    // A new transfer releases busy; the enable bit stays as written
    if (xfer_start) begin
      nxt_in_xfer  = 1'b1;
      nxt_rise_cnt = '0;
      nxt_fall_cnt = '0;
      nxt_busy_drv = 1'b0;
      nxt_busy_off = 1'b0;
      nxt_acknowledge_detected_clr = 1'b1;
      nxt_cmd_det  = 1'b0;
      nxt_free_det = 1'b0;
    end

    // Channel stopped: handshake state returns to idle; auto ack and busy enable stay as written
    if (!chan_en) begin
      nxt_cmd_det  = 1'b0;
      nxt_free_det = 1'b0;
      nxt_ack_det  = 1'b0;
      nxt_ack_pend = 1'b0;
      nxt_ack_drv  = 1'b0;
      nxt_busy_drv = 1'b0;
      nxt_busy_off = 1'b0;
      nxt_acknowledge_detected_clr = 1'b0;
      nxt_so_latch = 1'b1;
      nxt_in_xfer  = 1'b0;
      nxt_rise_cnt = '0;
      nxt_fall_cnt = '0;
      nxt_done     = 1'b0;
      ev           = '0;
    end
  end

  // ----------------------------------------------------------------
  // Event status: write one to clear, a new event wins
  // ----------------------------------------------------------------
  logic [SBC_IRQ_N-1:0] st_clr;

  always_comb begin
    st_clr = '0;
    if (reg_wr && reg_addr == SBC_OFS_IRQ_ST) begin
      st_clr = reg_wdata[SBC_IRQ_N-1:0];
    end
    nxt_irq_st = (irq_st_ff & ~st_clr) | ev;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == SBC_OFS_CTRL) begin
        // Triggers act at once and so always read back zero
        nxt_rdata[SBC_B_FREE_TRIG] = 1'b0;
        nxt_rdata[SBC_B_CMD_TRIG]  = 1'b0;
        nxt_rdata[SBC_B_ACK_TRIG]  = 1'b0;
        nxt_rdata[SBC_B_FREE_DET]  = free_det_ff;
        nxt_rdata[SBC_B_CMD_DET]   = cmd_det_ff;
        nxt_rdata[SBC_B_ACK_AUTO]  = ack_auto_ff;
        nxt_rdata[SBC_B_ACK_DET]   = ack_det_ff;
        nxt_rdata[SBC_B_BUSY_EN]   = busy_en_ff;
      end else if (reg_addr == SBC_OFS_MODE) begin
        nxt_rdata = mode_ff;
      end else if (reg_addr == SBC_OFS_IRQ_ST) begin
        nxt_rdata[SBC_IRQ_N-1:0] = irq_st_ff;
      end else begin
        nxt_rdata[SBC_IRQ_N-1:0] = irq_msk_ff;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_ff     <= SBC_MODE_RST;
      ack_auto_ff <= SBC_CTRL_RST[SBC_B_ACK_AUTO];
      busy_en_ff  <= SBC_CTRL_RST[SBC_B_BUSY_EN];
      cmd_det_ff  <= SBC_CTRL_RST[SBC_B_CMD_DET];
      free_det_ff <= SBC_CTRL_RST[SBC_B_FREE_DET];
      ack_det_ff  <= SBC_CTRL_RST[SBC_B_ACK_DET];
      ack_pend_ff <= 1'b0;
      ack_drv_ff  <= 1'b0;
      busy_drv_ff <= 1'b0;
      busy_off_ff <= 1'b0;
      acknowledge_detected_clr_ff <= 1'b0;
      so_latch_ff <= 1'b1;
      in_xfer_ff  <= 1'b0;
      rise_cnt_ff <= '0;
      fall_cnt_ff <= '0;
      done_ff     <= 1'b0;
      irq_st_ff   <= '0;
      irq_msk_ff  <= SBC_MSK_RST;
      rdata_ff    <= '0;
    end else begin
      mode_ff     <= nxt_mode;
      ack_auto_ff <= nxt_ack_auto;
      busy_en_ff  <= nxt_busy_en;
      cmd_det_ff  <= nxt_cmd_det;
      free_det_ff <= nxt_free_det;
      ack_det_ff  <= nxt_ack_det;
      ack_pend_ff <= nxt_ack_pend;
      ack_drv_ff  <= nxt_ack_drv;
      busy_drv_ff <= nxt_busy_drv;
      busy_off_ff <= nxt_busy_off;
      acknowledge_detected_clr_ff <= nxt_acknowledge_detected_clr;
      so_latch_ff <= nxt_so_latch;
      in_xfer_ff  <= nxt_in_xfer;
      rise_cnt_ff <= nxt_rise_cnt;
      fall_cnt_ff <= nxt_fall_cnt;
      done_ff     <= nxt_done;
      irq_st_ff   <= nxt_irq_st;
      irq_msk_ff  <= nxt_irq_msk;
      rdata_ff    <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain line: only ever pulled low, released otherwise
  assign sda_out   = 1'b0;
  assign sda_oe    = chan_en & (ack_drv_ff | busy_drv_ff | ~so_latch_ff);
  assign xfer_done = done_ff;
  assign reg_rdata = rdata_ff;
  assign irq       = |(irq_st_ff & irq_msk_ff);

endmodule

`default_nettype wire

//--- design/sbc_pkg.sv
package sbc_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned SBC_AW = 2;
  localparam int unsigned SBC_DW = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [SBC_AW-1:0] SBC_OFS_CTRL    = 2'h0; // serial_bus_control
  localparam logic [SBC_AW-1:0] SBC_OFS_MODE    = 2'h1; // serial_mode_register
  localparam logic [SBC_AW-1:0] SBC_OFS_IRQ_ST  = 2'h2; // sticky event status
  localparam logic [SBC_AW-1:0] SBC_OFS_IRQ_MSK = 2'h3; // event mask

  // ----------------------------------------------------------------
  // serial_bus_control fields
  // ----------------------------------------------------------------
  localparam int unsigned SBC_B_FREE_TRIG = 0;
  localparam int unsigned SBC_B_CMD_TRIG  = 1;
  localparam int unsigned SBC_B_FREE_DET  = 2;
  localparam int unsigned SBC_B_CMD_DET   = 3;
  localparam int unsigned SBC_B_ACK_TRIG  = 4;
  localparam int unsigned SBC_B_ACK_AUTO  = 5;
  localparam int unsigned SBC_B_ACK_DET   = 6;
  localparam int unsigned SBC_B_BUSY_EN   = 7;

  // ----------------------------------------------------------------
  // serial_mode_register fields
  // ----------------------------------------------------------------
  localparam int unsigned SBC_B_CHAN_EN = 7;

  // ----------------------------------------------------------------
  // Event status / mask fields
  // ----------------------------------------------------------------
  localparam int unsigned SBC_IRQ_N     = 4;
  localparam int unsigned SBC_E_CMD     = 0;
  localparam int unsigned SBC_E_FREE    = 1;
  localparam int unsigned SBC_E_ACK     = 2;
  localparam int unsigned SBC_E_DONE    = 3;

  // ----------------------------------------------------------------
  // Reset values and frame timing
  // ----------------------------------------------------------------
  localparam logic [SBC_DW-1:0]    SBC_CTRL_RST = 8'h00;
  localparam logic [SBC_DW-1:0]    SBC_MODE_RST = 8'h00;
  localparam logic [SBC_IRQ_N-1:0] SBC_MSK_RST  = 4'h0;
  localparam int unsigned          SBC_FRAME_BITS = 8;  // data bits before acknowledge

endpackage

//--- bench/sbc_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_chk
  import sbc_pkg::*;
#(
  parameter int unsigned FRAME_BITS = SBC_FRAME_BITS
) (
  input wire logic                       clk_sys,    // Clock
  input wire logic                       rst,        // Reset
  input wire logic [sbc_pkg::SBC_AW-1:0] reg_addr,   // Address
  input wire logic [sbc_pkg::SBC_DW-1:0] reg_wdata,  // Write data
  input wire logic                       reg_wr,     // Write strobe
  input wire logic                       reg_rd,     // Read strobe
  input wire logic [sbc_pkg::SBC_DW-1:0] reg_rdata,  // Read data
  input wire logic                       xfer_start, // Start pulse
  input wire logic                       sck_in,     // Serial clock
  input wire logic                       sda_in,     // Data line
  input wire logic                       sda_out,    // Drive value
  input wire logic                       sda_oe,     // Drive enable
  input wire logic                       xfer_done,  // Frame done
  input wire logic                       irq         // Interrupt
);
  // ------------------------------------------
  // Edge ages and shadow state
  // ------------------------------------------
  logic       sck_q_ff, chan_ff, msk_ff, nxt_sck_q, nxt_chan, nxt_msk;
  logic [3:0] fall_ff, rise_ff, nxt_fall, nxt_rise;

  always_comb begin
    nxt_sck_q = sck_in;
    nxt_fall  = (sck_q_ff && !sck_in) ? 4'h0 : fall_ff + {3'h0, fall_ff != 4'hf};
    nxt_rise  = (!sck_q_ff && sck_in) ? 4'h0 : rise_ff + {3'h0, rise_ff != 4'hf};
    nxt_chan  = chan_ff;
    nxt_msk   = msk_ff;
    if (reg_wr && reg_addr == SBC_OFS_MODE) begin
      nxt_chan = reg_wdata[SBC_B_CHAN_EN];
    end
    if (reg_wr && reg_addr == SBC_OFS_IRQ_MSK) begin
      nxt_msk = |reg_wdata[SBC_IRQ_N-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {sck_q_ff, fall_ff, rise_ff, chan_ff, msk_ff} <= {1'b1, 8'hff, 2'h0};
    end else begin
      {sck_q_ff, fall_ff, rise_ff, chan_ff, msk_ff} <=
        {nxt_sck_q, nxt_fall, nxt_rise, nxt_chan, nxt_msk};
    end
  end

  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_rd_ctrl;
    reg_rd && reg_addr == SBC_OFS_CTRL;
  endsequence
  sequence s_rd_st;
    reg_rd && reg_addr == SBC_OFS_IRQ_ST;
  endsequence

  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_trig_read_zero: assert property (s_rd_ctrl |=> reg_rdata[1:0] == 2'h0
    && !reg_rdata[SBC_B_ACK_TRIG]) else $error("trigger bit read back as one");
  a_status_upper: assert property (s_rd_st |=> reg_rdata[7:4] == 4'h0)
    else $error("unused status bits not zero");
  // Register writes and starts move the drive on their own; all else follows a falling edge
  a_oe_on_fall: assert property ($changed(sda_oe) && !$past(xfer_start) &&
    !$past(reg_wr) |-> fall_ff inside {[1:4]}) else $error("drive moved off a falling edge");
  a_busy_ends: assert property (xfer_start |=> !sda_oe)
    else $error("drive kept after transfer start");
  a_chan_off: assert property (!chan_ff |-> !sda_oe && !xfer_done)
    else $error("activity with channel disabled");
  a_done_rise: assert property (xfer_done |-> rise_ff inside {[1:4]} ##1 !xfer_done)
    else $error("frame done not a pulse after a rising edge");
  a_drive_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data line driven high");
  a_irq_masked: assert property (!msk_ff |-> !irq)
    else $error("interrupt with all events masked");
endmodule

bind sbc_ctrl sbc_chk #(.FRAME_BITS(FRAME_BITS)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_start(xfer_start),
  .sck_in(sck_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .xfer_done(xfer_done), .irq(irq)
);

`default_nettype wire

//--- bench/sbc_remote.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_remote (
  output logic sck,    // Serial clock, idle high
  output logic rem_oe  // High while pulling data low
);
  // ------------------------------------------
  // Remote station on the two-line bus
  // ------------------------------------------
  int half = 80;

  initial begin
    sck    = 1'b1;
    rem_oe = 1'b0;
  end

  // Edges 3 ns after a system edge, never racing it
  task automatic align();
    #((18 - $time % 10) % 10);
  endtask

  task automatic step(input logic v);
    align();
    sck = v;
    #half;
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      step(1'b0);
      step(1'b1);
    end
  endtask

  // Data moves while the clock stands high: command or free condition
  task automatic pull(input logic v);
    align();
    rem_oe = v;
    #half;
  endtask

  // Ninth bit, then the falling edge after it; clock left low
  task automatic ack_bit(input logic a);
    align();
    sck = 1'b0;
    #(half / 2) rem_oe = a;
    #(half / 2) sck = 1'b1;
    #half sck = 1'b0;
    #(half / 2) rem_oe = 1'b0;
    #(half / 2);
  endtask
endmodule

`default_nettype wire

//--- bench/sbc_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none

module sbc_ctrl_bench;
  import sbc_pkg::*;
  localparam int FB = 8;
  logic              clk_sys, rst, reg_wr, reg_rd, xfer_start;
  logic              sda_out, sda_oe, xfer_done, irq, rem_oe, sck_in;
  logic [SBC_AW-1:0] reg_addr;
  logic [SBC_DW-1:0] reg_wdata, reg_rdata, got;
  wire logic         sda_in;
  int                fail_count = 0;
  int                tests_run = 0;
  int                cyc = 0;
  int                done_n = 0;
  // Write flag, address, write data, expected read
  logic [18:0]       rows [10] = '{
    {1'b0, 2'h0, 8'h00, 8'h00}, {1'b0, 2'h1, 8'h00, 8'h00},
    {1'b0, 2'h2, 8'h00, 8'h00}, {1'b0, 2'h3, 8'h00, 8'h00},
    {1'b1, 2'h0, 8'hff, 8'ha0}, {1'b1, 2'h0, 8'h00, 8'h00},
    {1'b1, 2'h1, 8'h5a, 8'h5a}, {1'b1, 2'h3, 8'hff, 8'h0f},
    {1'b1, 2'h2, 8'h0f, 8'h00}, {1'b1, 2'h1, 8'h80, 8'h80}};

  // Pull-up on the data line
  assign sda_in = !(sda_oe || rem_oe);

  sbc_ctrl #(.FRAME_BITS(FB)) DUT (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_start(xfer_start),
    .sck_in(sck_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .xfer_done(xfer_done), .irq(irq)
  );
  sbc_remote rmt (.sck(sck_in), .rem_oe(rem_oe));

  // ------------------------------------------
  // Bus cycles and checks
  // ------------------------------------------
  task automatic wr(input logic [SBC_AW-1:0] a, input logic [SBC_DW-1:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [SBC_AW-1:0] a, output logic [SBC_DW-1:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic xs();
    @(posedge clk_sys);
    xfer_start <= 1'b1;
    @(posedge clk_sys);
    xfer_start <= 1'b0;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic ckpin(input logic ie, input logic oe);
    #1 cmp({5'h00, irq, sda_oe, sda_out}, {5'h00, ie, oe, 1'b0});
  endtask

  task automatic ckreg(input logic [SBC_AW-1:0] a, input logic [7:0] e);
    rd(a, got);
    cmp(got, e);
  endtask

  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (xfer_done) begin
      done_n <= done_n + 1;
    end
    if (cyc == 8000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, xfer_start, reg_addr, reg_wdata} = {1'b1, 13'h0000};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][18]) wr(rows[i][17:16], rows[i][15:8]);
      ckreg(rows[i][17:16], rows[i][7:0]);
    end
    rmt.pull(1'b1);
    ckreg(SBC_OFS_CTRL, 8'h08);
    ckpin(1'b1, 1'b0);
    rmt.pull(1'b0);
    ckreg(SBC_OFS_CTRL, 8'h04);
    wr(SBC_OFS_IRQ_MSK, 8'h00);
    ckpin(1'b0, 1'b0);
    wr(SBC_OFS_IRQ_MSK, 8'h02);
    ckpin(1'b1, 1'b0);
    wr(SBC_OFS_IRQ_ST, 8'h0f);
    ckpin(1'b0, 1'b0);
    wr(SBC_OFS_IRQ_MSK, 8'h00);
    // Auto ack, busy, then busy switched off mid-busy
    wr(SBC_OFS_CTRL, 8'ha0);
    xs();
    rmt.pulse(FB);
    cmp(8'(done_n), 8'h01);
    ckpin(1'b0, 1'b0);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b1);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b1);
    wr(SBC_OFS_CTRL, 8'h20);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b0);
    rmt.step(1'b1);
    // Remote ack on a slow clock
    wr(SBC_OFS_CTRL, 8'h00);
    wr(SBC_OFS_IRQ_ST, 8'h0f);
    rmt.half = 200;
    xs();
    rmt.pulse(FB);
    rmt.ack_bit(1'b1);
    rmt.step(1'b1);
    ckreg(SBC_OFS_CTRL, 8'h40);
    ckreg(SBC_OFS_IRQ_ST, 8'h0c);
    rmt.half = 80;
    xs();
    ckreg(SBC_OFS_CTRL, 8'h40);
    rmt.step(1'b0);
    ckreg(SBC_OFS_CTRL, 8'h00);
    rmt.step(1'b1);
    // Manual ack lasts one clock period
    xs();
    wr(SBC_OFS_CTRL, 8'h10);
    ckreg(SBC_OFS_CTRL, 8'h00);
    ckpin(1'b0, 1'b0);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b1);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b0);
    rmt.step(1'b1);
    // Auto ack enabled after the ninth falling edge has passed
    xs();
    rmt.pulse(FB + 1);
    cmp(8'(done_n), 8'h03);
    wr(SBC_OFS_CTRL, 8'ha0);
    ckpin(1'b0, 1'b0);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b1);
    rmt.step(1'b0);
    ckpin(1'b0, 1'b1);
    rmt.step(1'b1);
    xs();
    ckpin(1'b0, 1'b0);
    ckreg(SBC_OFS_CTRL, 8'ha0);
    // Output latch, channel off, reset in mid-run
    wr(SBC_OFS_CTRL, 8'h02);
    ckpin(1'b0, 1'b1);
    wr(SBC_OFS_CTRL, 8'h01);
    ckpin(1'b0, 1'b0);
    rmt.pull(1'b1);
    wr(SBC_OFS_MODE, 8'h00);
    rd(SBC_OFS_CTRL, got);
    cmp(got & 8'h4c, 8'h00);
    rmt.pull(1'b0);
    wr(SBC_OFS_MODE, 8'h80);
    rmt.pull(1'b1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    ckreg(SBC_OFS_CTRL, 8'h00);
    ckreg(SBC_OFS_MODE, 8'h00);
    rmt.pull(1'b0);
    end_sim();
  end
endmodule

`default_nettype wire
